// [ddp_serial_ctrl.v]
// Serial command interpreter and register file for the dual digital potentiometer
//
// Functional notes
// - Write-protect low blocks all setting writes
// - Serial input sampled on serial clock rise
// - Serial output floats unless shifting data
// - Wiper decoded to exactly one of 256 taps
// - Zero selects low end, all ones high
// - Two independent wiper position registers
// - Wiper: serial load, setting load, stepping
// - Power-up loads wiper from setting zero
// - Wiper volatile, restored only by recall
// - Four 8-bit settings per pot, read/write
// - Copy between settings and wiper both ways
// - Setting write finishes within ten milliseconds
// - Busy status bit reads 1 during write
// - First byte after select fall is identification
// - Continue only on full address match
// - Read data shifted out on clock fall
// - Serial ignored until first select fall
// - Hold pauses and resumes with clock low
// - Deselected: output floats, standby unless busy
`timescale 1ns/1ns
`include "ddp_defines.vh"

module ddp_serial_ctrl #(
   parameter NV_CNT_W = 18,
   parameter [NV_CNT_W-1:0] NV_WRITE_CYCLES = `DDP_NV_WRITE_CYCLES
)
(
   input wire i_core_clk,                // Core clock, 20 MHz
   input wire i_rst_n,                   // Synchronous reset, models power-up
   input wire i_sck,                     // Serial clock pin
   input wire i_cs_n,                    // Chip select pin, active low
   input wire i_si,                      // Serial data input pin
   input wire i_hold_n,                  // Pause pin, active low
   input wire i_wp_n,                    // Write-protect pin, active low
   input wire [3:0] i_address_strap_pins, // Slave address straps
   output reg o_so,                      // Serial data output value
   output reg o_so_oe,                   // Serial output enable
   output reg [7:0] o_wiper_position0,   // Pot 0 wiper position
   output reg [7:0] o_wiper_position1,   // Pot 1 wiper position
   output reg [255:0] o_tap_sel0,        // Pot 0 one-hot tap switches
   output reg [255:0] o_tap_sel1,        // Pot 1 one-hot tap switches
   output reg o_nv_write_busy,           // Setting write in progress
   output reg o_standby                  // Deselected and idle
);

   // ----------------------------------------
   // States
   // ----------------------------------------
   localparam [6:0] ST_IDLE = 7'h01;
   localparam [6:0] ST_ID = 7'h02;
   localparam [6:0] ST_INSTR = 7'h04;
   localparam [6:0] ST_DATA_IN = 7'h08;
   localparam [6:0] ST_DATA_OUT = 7'h10;
   localparam [6:0] ST_INC_DEC = 7'h20;
   localparam [6:0] ST_IGNORE = 7'h40;

   // ----------------------------------------
   // Functions
   // ----------------------------------------
   function [255:0] tap_decode;
      input [7:0] pos;
      begin
         tap_decode = {{255{1'b0}}, 1'b1} << pos;
      end
   endfunction

   // ----------------------------------------
   // Pin synchronisers
   // ----------------------------------------
   reg sck_s1_r, sck_s2_r, sck_d3_r;
   reg cs_s1_r, cs_s2_r, cs_d3_r;
   reg si_s1_r, si_s2_r;
   reg hold_s1_r, hold_s2_r;
   reg wp_s1_r, wp_s2_r;
   reg [3:0] strap_s1_r, strap_s2_r;

   always @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         sck_s1_r <= 1'b0;
         sck_s2_r <= 1'b0;
         sck_d3_r <= 1'b0;
         // Select starts low so a pin already low at power-up is no fall
         cs_s1_r <= 1'b0;
         cs_s2_r <= 1'b0;
         cs_d3_r <= 1'b0;
         si_s1_r <= 1'b0;
         si_s2_r <= 1'b0;
         hold_s1_r <= 1'b1;
         hold_s2_r <= 1'b1;
         wp_s1_r <= 1'b0;
         wp_s2_r <= 1'b0;
         strap_s1_r <= 4'h0;
         strap_s2_r <= 4'h0;
      end
      else
      begin
         sck_s1_r <= i_sck;
         sck_s2_r <= sck_s1_r;
         sck_d3_r <= sck_s2_r;
         cs_s1_r <= i_cs_n;
         cs_s2_r <= cs_s1_r;
         cs_d3_r <= cs_s2_r;
         si_s1_r <= i_si;
         si_s2_r <= si_s1_r;
         hold_s1_r <= i_hold_n;
         hold_s2_r <= hold_s1_r;
         wp_s1_r <= i_wp_n;
         wp_s2_r <= wp_s1_r;
         strap_s1_r <= i_address_strap_pins;
         strap_s2_r <= strap_s1_r;
      end
   end

   // ----------------------------------------
   // State
   // ----------------------------------------
   reg [6:0] state_r;
   reg held_r;
   reg [2:0] bit_cnt_r;
   reg [6:0] shift_r;
   reg [7:0] instr_r;
   reg [7:0] out_sh_r;
   reg [7:0] wiper_r [0:1];
   reg [7:0] setting_mem [0:7];
   reg recall_r;
   reg so_on_r;
   reg [NV_CNT_W-1:0] nv_cnt_r;
   reg [1:0] pend_mask_r;
   reg [1:0] pend_idx_r;
   reg [7:0] pend_data0_r;
   reg [7:0] pend_data1_r;

   wire sck_rise = sck_s2_r & ~sck_d3_r & ~held_r;
   wire sck_fall = ~sck_s2_r & sck_d3_r & ~held_r;
   wire frame_start = ~cs_s2_r & cs_d3_r;
   wire [7:0] byte_in = {shift_r, si_s2_r};
   wire [3:0] op = instr_r[`DDP_INS_OP_MSB:`DDP_INS_OP_LSB];
   wire [1:0] idx = instr_r[`DDP_INS_IDX_MSB:`DDP_INS_IDX_LSB];
   wire pot = instr_r[`DDP_INS_POT];
   wire [3:0] in_op = byte_in[`DDP_INS_OP_MSB:`DDP_INS_OP_LSB];
   wire [1:0] in_idx = byte_in[`DDP_INS_IDX_MSB:`DDP_INS_IDX_LSB];
   wire in_pot = byte_in[`DDP_INS_POT];
   wire nv_busy = (nv_cnt_r != {NV_CNT_W{1'b0}});
   wire nv_ok = wp_s2_r & ~nv_busy;
   integer k;

   // ----------------------------------------
   // Serial engine, registers and write cycle
   // ----------------------------------------
   always @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         state_r <= ST_IDLE;
         held_r <= 1'b0;
         bit_cnt_r <= 3'h0;
         shift_r <= 7'h00;
         instr_r <= 8'h00;
         out_sh_r <= 8'h00;
         o_so <= 1'b0;
         o_so_oe <= 1'b0;
         wiper_r[0] <= 8'h00;
         wiper_r[1] <= 8'h00;
         for (k = 0; k < 8; k = k + 1)
            setting_mem[k] <= `DDP_SETTING_RESET;
         recall_r <= 1'b1;
         so_on_r <= 1'b0;
         nv_cnt_r <= {NV_CNT_W{1'b0}};
         pend_mask_r <= 2'b00;
         pend_idx_r <= 2'b00;
         pend_data0_r <= 8'h00;
         pend_data1_r <= 8'h00;
      end
      else
      begin
         // Wiper holds no value of its own after power-up until recalled
         if (recall_r)
         begin
            wiper_r[0] <= setting_mem[0];
            wiper_r[1] <= setting_mem[4];
            recall_r <= 1'b0;
         end
         if (cs_s2_r)
         begin
            state_r <= ST_IDLE;
            held_r <= 1'b0;
            so_on_r <= 1'b0;
            o_so_oe <= 1'b0;
         end
         else if (frame_start)
         begin
            state_r <= ST_ID;
            bit_cnt_r <= 3'h0;
            held_r <= 1'b0;
            so_on_r <= 1'b0;
         end
         else if (state_r != ST_IDLE)
         begin
            if (!sck_s2_r)
               held_r <= ~hold_s2_r;
            if (held_r)
               o_so_oe <= 1'b0;
            // Resume drives the pending bit again, so a pause loses no data
            else if (so_on_r)
               o_so_oe <= 1'b1;
            if (sck_rise)
            begin
               shift_r <= byte_in[6:0];
               bit_cnt_r <= bit_cnt_r + 3'h1;
               if (state_r == ST_INC_DEC)
               begin
                  if (si_s2_r && wiper_r[pot] != 8'hFF)
                     wiper_r[pot] <= wiper_r[pot] + 8'h01;
                  else if (!si_s2_r && wiper_r[pot] != 8'h00)
                     wiper_r[pot] <= wiper_r[pot] - 8'h01;
               end
               else if (bit_cnt_r == 3'h7)
               begin
                  case (state_r)
                     ST_ID:
                     begin
                        if (byte_in[7:4] == `DDP_DEVICE_TYPE && byte_in[3:0] == strap_s2_r)
                           state_r <= ST_INSTR;
                        else
                           state_r <= ST_IGNORE;
                     end
                     ST_INSTR:
                     begin
                        instr_r <= byte_in;
                        state_r <= ST_IGNORE;
                        case (in_op)
                           `DDP_OP_WR_WIPER, `DDP_OP_WR_SET:
                              state_r <= ST_DATA_IN;
                           `DDP_OP_RD_WIPER:
                           begin
                              out_sh_r <= wiper_r[in_pot];
                              state_r <= ST_DATA_OUT;
                           end
                           `DDP_OP_RD_SET:
                           begin
                              out_sh_r <= setting_mem[{in_pot, in_idx}];
                              state_r <= ST_DATA_OUT;
                           end
                           `DDP_OP_RD_STATUS:
                           begin
                              out_sh_r <= 8'h00;
                              out_sh_r[`DDP_STATUS_BUSY_BIT] <= nv_busy;
                              state_r <= ST_DATA_OUT;
                           end
                           `DDP_OP_INC_DEC:
                              state_r <= ST_INC_DEC;
                           `DDP_OP_SET_TO_WIPER:
                              wiper_r[in_pot] <= setting_mem[{in_pot, in_idx}];
                           `DDP_OP_GLB_SET_TO_WIPER:
                           begin
                              wiper_r[0] <= setting_mem[{1'b0, in_idx}];
                              wiper_r[1] <= setting_mem[{1'b1, in_idx}];
                           end
                           `DDP_OP_WIPER_TO_SET:
                           begin
                              if (nv_ok)
                              begin
                                 nv_cnt_r <= NV_WRITE_CYCLES;
                                 pend_mask_r <= in_pot ? 2'b10 : 2'b01;
                                 pend_idx_r <= in_idx;
                                 pend_data0_r <= wiper_r[0];
                                 pend_data1_r <= wiper_r[1];
                              end
                           end
                           `DDP_OP_GLB_WIPER_TO_SET:
                           begin
                              if (nv_ok)
                              begin
                                 nv_cnt_r <= NV_WRITE_CYCLES;
                                 pend_mask_r <= 2'b11;
                                 pend_idx_r <= in_idx;
                                 pend_data0_r <= wiper_r[0];
                                 pend_data1_r <= wiper_r[1];
                              end
                           end
                           default:
                              state_r <= ST_IGNORE;
                        endcase
                     end
                     ST_DATA_IN:
                     begin
                        state_r <= ST_IGNORE;
                        if (op == `DDP_OP_WR_WIPER)
                           wiper_r[pot] <= byte_in;
                        else if (nv_ok)
                        begin
                           nv_cnt_r <= NV_WRITE_CYCLES;
                           pend_mask_r <= pot ? 2'b10 : 2'b01;
                           pend_idx_r <= idx;
                           pend_data0_r <= byte_in;
                           pend_data1_r <= byte_in;
                        end
                     end
                     default:
                        state_r <= state_r;
                  endcase
               end
            end
            if (sck_fall && state_r == ST_DATA_OUT)
            begin
               o_so <= out_sh_r[7];
               out_sh_r <= {out_sh_r[6:0], 1'b0};
               o_so_oe <= 1'b1;
               so_on_r <= 1'b1;
            end
         end
         // Commit lands at the end so a reader sees the old value until done
         if (nv_busy)
         begin
            nv_cnt_r <= nv_cnt_r - {{(NV_CNT_W-1){1'b0}}, 1'b1};
            if (nv_cnt_r == {{(NV_CNT_W-1){1'b0}}, 1'b1})
            begin
               if (pend_mask_r[0])
                  setting_mem[{1'b0, pend_idx_r}] <= pend_data0_r;
               if (pend_mask_r[1])
                  setting_mem[{1'b1, pend_idx_r}] <= pend_data1_r;
            end
         end
      end
   end

   // ----------------------------------------
   // Registered outputs
   // ----------------------------------------
   always @(posedge i_core_clk)
   begin
      if (!i_rst_n)
      begin
         o_wiper_position0 <= 8'h00;
         o_wiper_position1 <= 8'h00;
         o_tap_sel0 <= {{255{1'b0}}, 1'b1};
         o_tap_sel1 <= {{255{1'b0}}, 1'b1};
         o_nv_write_busy <= 1'b0;
         o_standby <= 1'b0;
      end
      else
      begin
         o_wiper_position0 <= wiper_r[0];
         o_wiper_position1 <= wiper_r[1];
         // One cycle behind the wiper; a single shifted bit keeps one tap on
         o_tap_sel0 <= tap_decode(wiper_r[0]);
         o_tap_sel1 <= tap_decode(wiper_r[1]);
         o_nv_write_busy <= nv_busy;
         o_standby <= cs_s2_r & ~nv_busy;
      end
   end

endmodule

// [ddp_defines.vh]
// Constants for the dual digital potentiometer serial control block
`ifndef DDP_DEFINES_VH
`define DDP_DEFINES_VH

// ----------------------------------------
// Identification byte
// ----------------------------------------
// Device type nibble, value is arbitrary
`define DDP_DEVICE_TYPE 4'hA

// ----------------------------------------
// Instruction opcodes, bits [7:4]
// ----------------------------------------
`define DDP_OP_RD_WIPER 4'h9
`define DDP_OP_WR_WIPER 4'hA
`define DDP_OP_RD_SET 4'hB
`define DDP_OP_WR_SET 4'hC
`define DDP_OP_SET_TO_WIPER 4'hD
`define DDP_OP_WIPER_TO_SET 4'hE
`define DDP_OP_GLB_SET_TO_WIPER 4'h1
`define DDP_OP_GLB_WIPER_TO_SET 4'h8
`define DDP_OP_INC_DEC 4'h2
`define DDP_OP_RD_STATUS 4'h5

// ----------------------------------------
// Instruction field positions
// ----------------------------------------
`define DDP_INS_OP_MSB 7
`define DDP_INS_OP_LSB 4
`define DDP_INS_IDX_MSB 3
`define DDP_INS_IDX_LSB 2
`define DDP_INS_POT 0

// ----------------------------------------
// Reset values and status bit position
// ----------------------------------------
`define DDP_SETTING_RESET 8'h80
`define DDP_STATUS_BUSY_BIT 0

// ----------------------------------------
// Timing
// ----------------------------------------
`define DDP_CORE_CLK_PERIOD_NS 50
`define DDP_NV_WRITE_TIME_NS 10_000_000
// Ten milliseconds of 50 ns core cycles, sized to the write counter
`define DDP_NV_WRITE_CYCLES 18'h3_0d40

`endif

// [ddp_host_model.sv]
// Serial host model that drives the pins of the potentiometer control block
`timescale 1ns/1ns
module ddp_host_model (
   input wire i_core_clk, // Core clock used for pacing
   input wire i_so,       // Serial output value
   input wire i_so_oe,    // Serial output enable
   output reg o_sck,      // Serial clock, still between frames
   output reg o_cs_n,     // Chip select, active low
   output reg o_si,       // Serial data to the device
   output reg o_hold_n    // Pause, active low
);
   // A released output reads as z so a stale level can never match
   wire so_w = i_so_oe ? i_so : 1'bz;
   initial
   begin
      o_sck = 1'b0;
      o_cs_n = 1'b1;
      o_si = 1'b0;
      o_hold_n = 1'b1;
   end
   task cyc(input int n);
      repeat (n) @(posedge i_core_clk);
      #1;
   endtask
   // ----------------------------------------
   // One frame: n bits from bits[31] down, pause before bit hp
   // ----------------------------------------
   task frame(input int n, input [31:0] bits, input int hp, output logic [7:0] rx);
      int i;
      o_cs_n = 1'b0;
      cyc(4);
      for (i = 0; i < n; i++)
      begin
         o_sck = 1'b0;
         o_si = bits[31-i];
         if (i == hp)
         begin
            cyc(2);
            o_hold_n = 1'b0;
            cyc(8);
            o_hold_n = 1'b1;
         end
         cyc(4);
         o_sck = 1'b1;
         cyc(4);
         rx = {rx[6:0], so_w};
      end
      o_sck = 1'b0;
      cyc(4);
      o_cs_n = 1'b1;
      o_si = ~o_si;
      cyc(4);
   endtask
endmodule

// [ddp_serial_ctrl_chk.sv]
// Port checker for the potentiometer serial control block
`timescale 1ns/1ns
module ddp_chk #(
   parameter NV_CNT_W = 18,
   parameter [NV_CNT_W-1:0] NV_WRITE_CYCLES = 18'h3_0d40
)
(
   input wire logic i_core_clk,                // Core clock
   input wire logic i_rst_n,                   // Synchronous reset
   input wire logic i_sck,                     // Serial clock pin
   input wire logic i_cs_n,                    // Chip select pin
   input wire logic i_hold_n,                  // Pause pin
   input wire logic i_wp_n,                    // Write-protect pin
   input wire logic o_so_oe,                   // Serial output enable
   input wire logic [7:0] o_wiper_position0,   // Pot 0 wiper
   input wire logic [7:0] o_wiper_position1,   // Pot 1 wiper
   input wire logic [255:0] o_tap_sel0,        // Pot 0 taps
   input wire logic [255:0] o_tap_sel1,        // Pot 1 taps
   input wire logic o_nv_write_busy,           // Setting write running
   input wire logic o_standby                  // Idle and deselected
);
   default clocking @(posedge i_core_clk); endclocking
   default disable iff (!i_rst_n);
   // Busy length counted here, too long for a repetition
   logic [NV_CNT_W-1:0] busy_cnt_r;
   logic [NV_CNT_W-1:0] busy_cnt_nxt;
   assign busy_cnt_nxt = o_nv_write_busy ? busy_cnt_r + 1'b1 : '0;
   always @(posedge i_core_clk)
   begin
      if (!i_rst_n)
         busy_cnt_r <= '0;
      else
         busy_cnt_r <= busy_cnt_nxt;
   end
   a_tap_one_hot: assert property ($onehot(o_tap_sel0) && $onehot(o_tap_sel1))
      else $error("tap select not one-hot");
   a_tap_tracks_wiper: assert property (o_tap_sel0 == (256'h1 << o_wiper_position0)
      && o_tap_sel1 == (256'h1 << o_wiper_position1)) else $error("tap does not match wiper");
   a_so_off_deselect: assert property (i_cs_n [*5] |-> !o_so_oe)
      else $error("output driven while deselected");
   a_standby_not_busy: assert property (o_standby |-> !o_nv_write_busy)
      else $error("standby during setting write");
   a_standby_entry: assert property ((i_cs_n && !o_nv_write_busy) [*6] |=> o_standby)
      else $error("no standby when idle");
   a_busy_length: assert property ($fell(o_nv_write_busy) |-> busy_cnt_r == NV_WRITE_CYCLES)
      else $error("busy length wrong");
   a_busy_bound: assert property (o_nv_write_busy |-> busy_cnt_r < NV_WRITE_CYCLES)
      else $error("setting write too long");
   a_wp_blocks_write: assert property ((!i_wp_n) [*8] |=> !$rose(o_nv_write_busy))
      else $error("write started while protected");
   a_wiper_idle: assert property (i_cs_n [*8] |=> $stable(o_wiper_position0)
      && $stable(o_wiper_position1)) else $error("wiper moved while deselected");
   a_hold_off: assert property ((!i_hold_n && !i_sck) [*6] |=> !o_so_oe)
      else $error("output driven during pause");
endmodule
bind ddp_serial_ctrl ddp_chk #(.NV_CNT_W(NV_CNT_W), .NV_WRITE_CYCLES(NV_WRITE_CYCLES))
   ddp_chk_inst (.i_core_clk, .i_rst_n, .i_sck, .i_cs_n, .i_hold_n, .i_wp_n, .o_so_oe,
   .o_wiper_position0, .o_wiper_position1, .o_tap_sel0, .o_tap_sel1, .o_nv_write_busy,
   .o_standby);

// [tb.sv]
// Self-checking bench for the dual potentiometer serial control block
`timescale 1ns/1ns
`include "ddp_defines.vh"
module tb;
   // Short write time keeps the run small; status reads still land inside it
   localparam logic [17:0] NVC = 18'h0_03e8;
   logic clk = 1'b0, rst_n = 1'b0, wp_n = 1'b1;
   logic [3:0] strap = 4'h6;
   wire sck, cs_n, si, hold_n, so, so_oe, busy, stby;
   wire [7:0] wp0, wp1;
   wire [255:0] tap0, tap1;
   int n_fail = 0, n_checks = 0, hp = 99;
   logic [31:0] seed = 32'h941c;
   logic [7:0] st [2][4];
   logic [7:0] nv_write_busy [2];
   logic [7:0] rx;
   ddp_serial_ctrl #(.NV_WRITE_CYCLES(NVC)) ddp_serial_ctrl_inst (.i_core_clk(clk),
      .i_rst_n(rst_n), .i_sck(sck), .i_cs_n(cs_n), .i_si(si), .i_hold_n(hold_n),
      .i_wp_n(wp_n), .i_address_strap_pins(strap), .o_so(so), .o_so_oe(so_oe),
      .o_wiper_position0(wp0), .o_wiper_position1(wp1), .o_tap_sel0(tap0),
      .o_tap_sel1(tap1), .o_nv_write_busy(busy), .o_standby(stby));
   ddp_host_model ddp_host_model_inst (.i_core_clk(clk), .i_so(so), .i_so_oe(so_oe),
      .o_sck(sck), .o_cs_n(cs_n), .o_si(si), .o_hold_n(hold_n));
   initial
   begin
      forever #25 clk = ~clk;
   end
   function [31:0] lfsr(input [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   function [7:0] step(input [7:0] w, input up);
      step = up ? ((w == 8'hff) ? w : w + 8'h01) : ((w == 8'h00) ? w : w - 8'h01);
   endfunction
   task chk(input string what, input [7:0] exp, input [7:0] got);
      n_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task op(input [3:0] opc, input [1:0] ix, input p, input [7:0] d);
      ddp_host_model_inst.frame(24, {`DDP_DEVICE_TYPE, strap, opc, ix, 1'b0, p, d, 8'h00},
         hp, rx);
   endtask
   task nvwait;
      repeat (NVC + 8) @(posedge clk);
      #1;
   endtask
   task close_out;
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   initial
   begin
      #(40_000 * 50);
      n_fail++;
      $display("unexpected run length: expected end, seen timeout");
      close_out;
   end
   initial
   begin
      int p, i;
      logic [7:0] v, t;
      for (p = 0; p < 2; p++)
      begin
         nv_write_busy[p] = `DDP_SETTING_RESET;
         for (i = 0; i < 4; i++)
            st[p][i] = `DDP_SETTING_RESET;
      end
      repeat (20) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("wiper0 port", nv_write_busy[0], wp0);
      chk("wiper1 port", nv_write_busy[1], wp1);
      $display("test recall done");
      seed = lfsr(seed);
      strap = seed[3:0];
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         p = i % 2;
         v = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : seed[7:0];
         op(`DDP_OP_WR_WIPER, 2'd0, p[0], v);
         nv_write_busy[p] = v;
         hp = (i == 3) ? 18 : 99;
         op(`DDP_OP_RD_WIPER, 2'd0, p[0], 8'h00);
         hp = 99;
         chk("wiper read", v, rx);
         chk("wiper port", nv_write_busy[p], p ? wp1 : wp0);
      end
      $display("test wiper done");
      for (i = 0; i < 4; i++)
      begin
         seed = lfsr(seed);
         p = seed[8];
         v = seed[7:0];
         op(`DDP_OP_WR_SET, i[1:0], p[0], v);
         op(`DDP_OP_RD_SET, i[1:0], p[0], 8'h00);
         chk("setting during write", st[p][i], rx);
         op(`DDP_OP_RD_STATUS, 2'd0, 1'b0, 8'h00);
         chk("status busy", 8'h01, rx);
         op(`DDP_OP_WR_SET, i[1:0], p[0], ~v);
         nvwait;
         st[p][i] = v;
         op(`DDP_OP_RD_SET, i[1:0], p[0], 8'h00);
         chk("setting", v, rx);
         op(`DDP_OP_RD_STATUS, 2'd0, 1'b0, 8'h00);
         chk("status idle", 8'h00, rx);
      end
      $display("test settings done");
      wp_n = 1'b0;
      op(`DDP_OP_WR_SET, 2'd1, 1'b0, ~st[0][1]);
      op(`DDP_OP_WIPER_TO_SET, 2'd2, 1'b1, 8'h00);
      chk("busy protected", 8'h00, {7'h0, busy});
      nvwait;
      wp_n = 1'b1;
      op(`DDP_OP_RD_SET, 2'd1, 1'b0, 8'h00);
      chk("protected setting", st[0][1], rx);
      $display("test protect done");
      op(`DDP_OP_SET_TO_WIPER, 2'd3, 1'b1, 8'h00);
      nv_write_busy[1] = st[1][3];
      chk("wiper from setting", nv_write_busy[1], wp1);
      op(`DDP_OP_WIPER_TO_SET, 2'd0, 1'b0, 8'h00);
      nvwait;
      st[0][0] = nv_write_busy[0];
      op(`DDP_OP_GLB_WIPER_TO_SET, 2'd2, 1'b0, 8'h00);
      nvwait;
      st[0][2] = nv_write_busy[0];
      st[1][2] = nv_write_busy[1];
      op(`DDP_OP_GLB_SET_TO_WIPER, 2'd0, 1'b0, 8'h00);
      nv_write_busy[0] = st[0][0];
      nv_write_busy[1] = st[1][0];
      chk("global wiper0", nv_write_busy[0], wp0);
      chk("global wiper1", nv_write_busy[1], wp1);
      op(`DDP_OP_RD_SET, 2'd2, 1'b1, 8'h00);
      chk("global setting", st[1][2], rx);
      $display("test transfer done");
      for (p = 0; p < 3; p++)
      begin
         seed = lfsr(seed);
         v = (p == 0) ? 8'hfd : (p == 1) ? 8'h02 : seed[15:8];
         t = (p == 0) ? 8'hf8 : (p == 1) ? 8'h01 : seed[7:0];
         op(`DDP_OP_WR_WIPER, 2'd0, p[0], v);
         op(`DDP_OP_INC_DEC, 2'd0, p[0], t);
         for (i = 0; i < 8; i++)
            v = step(v, t[7-i]);
         nv_write_busy[p % 2] = v;
         chk("stepped wiper", v, p[0] ? wp1 : wp0);
      end
      $display("test step done");
      for (i = 0; i < 2; i++)
      begin
         ddp_host_model_inst.frame(24, {`DDP_DEVICE_TYPE ^ {i[0], 3'h0},
            strap ^ {3'h0, ~i[0]}, `DDP_OP_WR_WIPER, 4'h0, ~nv_write_busy[0], 8'h00}, 99, rx);
         chk("wiper unmatched", nv_write_busy[0], wp0);
      end
      $display("test address done");
      rst_n = 1'b0;
      repeat (2) @(posedge clk);
      #1 rst_n = 1'b1;
      repeat (4) @(posedge clk);
      #1;
      chk("wiper0 after reset", `DDP_SETTING_RESET, wp0);
      chk("wiper1 after reset", `DDP_SETTING_RESET, wp1);
      $display("test reset done");
      close_out;
   end
endmodule
